// file: design/tope_timer.sv
// Timer core with one-pulse output generation and quadrature encoder counting
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "tope_params.svh"
module tope_timer
  import tope_pkg::*;
#(
  parameter int CW = 16,
  parameter int PW = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic encoder_input_a,
  input wire logic encoder_input_b,
  output logic output_reference,
  output logic [CW-1:0] counter_value,
  output logic count_down_flag
);
  if (CW < 2 || CW > 32 || PW < 1 || PW > 32) begin : g_bad_width
    $error("tope_timer: CW or PW out of range");
  end

  // Bus and register state
  tope_apb_st_t ap_st_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic run_q, single_q, down_q, perpre_q;
  logic [2:0] sms_q, ts_q, ocm_q;
  logic [1:0] sel1_q, sel2_q;
  logic fast_q, cpre_q, pola_q, polb_q;
  logic [3:0] flta_q, fltb_q;
  logic [CW-1:0] cnt_q, arr_q, arr_sh_q, ccr_q, ccr_sh_q;
  logic [PW-1:0] psc_q, psc_sh_q, psc_cnt_q;
  logic ref_q, fast_hold_q, match_q;

  // Conditioned encoder inputs
  logic a_lvl, a_rise, a_fall, b_lvl, b_rise, b_fall;

  tope_input_cond #(.FW(4)) u_cond_a (
    .core_clk(core_clk),
    .rst(rst),
    .raw_in(encoder_input_a),
    .invert(pola_q),
    .filter_len(flta_q),
    .level_q(a_lvl),
    .rise_q(a_rise),
    .fall_q(a_fall)
  );

  tope_input_cond #(.FW(4)) u_cond_b (
    .core_clk(core_clk),
    .rst(rst),
    .raw_in(encoder_input_b),
    .invert(polb_q),
    .filter_len(fltb_q),
    .level_q(b_lvl),
    .rise_q(b_rise),
    .fall_q(b_fall)
  );

  // Word-aligned decode of the mapped offsets
  function automatic logic addr_hit(input logic [11:0] a);
    case (a)
      `TOPE_OFS_CTRL, `TOPE_OFS_SMODE, `TOPE_OFS_EVGEN, `TOPE_OFS_CHMODE, `TOPE_OFS_CAPEN,
      `TOPE_OFS_COUNT, `TOPE_OFS_PRESC, `TOPE_OFS_RELOAD, `TOPE_OFS_CMP1: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  function automatic logic pwm_mode(input logic [2:0] m);
    pwm_mode = (m == `TOPE_OCM_PWM1) || (m == `TOPE_OCM_PWM2);
  endfunction

  logic acc, wr_en;
  logic wr_ctrl, wr_smode, wr_evgen, wr_chmode, wr_capen, wr_count, wr_presc, wr_reload, wr_cmp1;
  logic force_upd;

  assign acc = psel && penable;
  assign pready = (ap_st_q == TOPE_AP_RESP);
  assign pslverr = pready && err_q;
  assign prdata = prdata_q;
  assign wr_en = acc && pready && pwrite && !err_q;
  assign wr_ctrl = wr_en && (paddr == `TOPE_OFS_CTRL);
  assign wr_smode = wr_en && (paddr == `TOPE_OFS_SMODE);
  assign wr_evgen = wr_en && (paddr == `TOPE_OFS_EVGEN);
  assign wr_chmode = wr_en && (paddr == `TOPE_OFS_CHMODE);
  assign wr_capen = wr_en && (paddr == `TOPE_OFS_CAPEN);
  assign wr_count = wr_en && (paddr == `TOPE_OFS_COUNT);
  assign wr_presc = wr_en && (paddr == `TOPE_OFS_PRESC);
  assign wr_reload = wr_en && (paddr == `TOPE_OFS_RELOAD);
  assign wr_cmp1 = wr_en && (paddr == `TOPE_OFS_CMP1);
  assign force_upd = wr_evgen && pwdata[`TOPE_EVGEN_UPD];

  // One wait state so read data can come from a flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ap_st_q <= TOPE_AP_IDLE;
      err_q <= 1'b0;
    end else begin
      case (ap_st_q)
        TOPE_AP_IDLE: begin
          if (acc) begin
            ap_st_q <= TOPE_AP_RESP;
            err_q <= !addr_hit(paddr);
          end
        end
        TOPE_AP_RESP: ap_st_q <= TOPE_AP_IDLE;
        default: ap_st_q <= TOPE_AP_IDLE;
      endcase
    end
  end

  // Read mux captured in the first access cycle; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= `TOPE_RST_WORD;
    end else if (acc && ap_st_q == TOPE_AP_IDLE) begin
      prdata_q <= `TOPE_RST_WORD;
      case (paddr)
        `TOPE_OFS_CTRL: begin
          prdata_q[`TOPE_CTRL_RUN] <= run_q;
          prdata_q[`TOPE_CTRL_SINGLE] <= single_q;
          prdata_q[`TOPE_CTRL_DOWN] <= down_q;
          prdata_q[`TOPE_CTRL_PERPRE] <= perpre_q;
        end
        `TOPE_OFS_SMODE: begin
          prdata_q[`TOPE_SMODE_SMS] <= sms_q;
          prdata_q[`TOPE_SMODE_TS] <= ts_q;
        end
        `TOPE_OFS_CHMODE: begin
          prdata_q[`TOPE_CH_SEL1] <= sel1_q;
          prdata_q[`TOPE_CH_FAST] <= fast_q;
          prdata_q[`TOPE_CH_CPRE] <= cpre_q;
          prdata_q[`TOPE_CH_OCM] <= ocm_q;
          prdata_q[`TOPE_CH_SEL2] <= sel2_q;
          prdata_q[`TOPE_CH_FLTA] <= flta_q;
          prdata_q[`TOPE_CH_FLTB] <= fltb_q;
        end
        `TOPE_OFS_CAPEN: begin
          prdata_q[`TOPE_CAP_POLA] <= pola_q;
          prdata_q[`TOPE_CAP_POLB] <= polb_q;
        end
        `TOPE_OFS_COUNT: prdata_q[CW-1:0] <= cnt_q;
        `TOPE_OFS_PRESC: prdata_q[PW-1:0] <= psc_q;
        `TOPE_OFS_RELOAD: prdata_q[CW-1:0] <= arr_q;
        `TOPE_OFS_CMP1: prdata_q[CW-1:0] <= ccr_q;
        default: prdata_q <= `TOPE_RST_WORD;
      endcase
    end
  end

  // Mode and configuration fields
  always_ff @(posedge core_clk) begin
    if (rst) begin
      single_q <= 1'b0;
      perpre_q <= 1'b0;
      sms_q <= 3'h0;
      ts_q <= 3'h0;
      sel1_q <= 2'h0;
      sel2_q <= 2'h0;
      fast_q <= 1'b0;
      cpre_q <= 1'b0;
      ocm_q <= `TOPE_OCM_FROZEN;
      flta_q <= 4'h0;
      fltb_q <= 4'h0;
      pola_q <= 1'b0;
      polb_q <= 1'b0;
      psc_q <= '0;
      arr_q <= CW'(`TOPE_RST_RELOAD);
      ccr_q <= '0;
    end else begin
      if (wr_ctrl) begin
        single_q <= pwdata[`TOPE_CTRL_SINGLE];
        perpre_q <= pwdata[`TOPE_CTRL_PERPRE];
      end
      if (wr_smode) begin
        sms_q <= pwdata[`TOPE_SMODE_SMS];
        ts_q <= pwdata[`TOPE_SMODE_TS];
      end
      if (wr_chmode) begin
        sel1_q <= pwdata[`TOPE_CH_SEL1];
        fast_q <= pwdata[`TOPE_CH_FAST];
        cpre_q <= pwdata[`TOPE_CH_CPRE];
        ocm_q <= pwdata[`TOPE_CH_OCM];
        sel2_q <= pwdata[`TOPE_CH_SEL2];
        flta_q <= pwdata[`TOPE_CH_FLTA];
        fltb_q <= pwdata[`TOPE_CH_FLTB];
      end
      if (wr_capen) begin
        pola_q <= pwdata[`TOPE_CAP_POLA];
        polb_q <= pwdata[`TOPE_CAP_POLB];
      end
      if (wr_presc) psc_q <= pwdata[PW-1:0];
      if (wr_reload) arr_q <= pwdata[CW-1:0];
      if (wr_cmp1) ccr_q <= pwdata[CW-1:0];
    end
  end

  // Trigger and encoder event decode
  logic enc_mode, trig, a_edge, b_edge, enc_valid, enc_down, enc_count;
  assign enc_mode = (sms_q == `TOPE_SMS_ENC_B) || (sms_q == `TOPE_SMS_ENC_A) || (sms_q == `TOPE_SMS_ENC_AB);
  assign trig = (sms_q == `TOPE_SMS_TRIG) &&
                (((ts_q == `TOPE_TS_INB) && (sel2_q == `TOPE_SEL_DIRECT) && b_rise) ||
                 ((ts_q == `TOPE_TS_INA) && (sel1_q == `TOPE_SEL_DIRECT) && a_rise));
  assign a_edge = a_rise || a_fall;
  assign b_edge = b_rise || b_fall;
  assign enc_valid = a_edge ^ b_edge;
  // Direction from the opposite input's level at the edge
  assign enc_down = a_edge ? (a_rise ? b_lvl : !b_lvl) : (b_rise ? !a_lvl : a_lvl);
  assign enc_count = enc_mode && run_q && enc_valid &&
                     ((a_edge && sms_q != `TOPE_SMS_ENC_B) || (b_edge && sms_q != `TOPE_SMS_ENC_A));

  // Prescaler: internal clock normally, encoder events in encoder mode
  logic src_evt, psc_tick, step, step_down, wrap, update_event, opm_stop;
  assign src_evt = enc_mode ? enc_count : run_q;
  assign psc_tick = (psc_cnt_q == psc_sh_q);
  assign step = src_evt && psc_tick;
  assign step_down = enc_mode ? enc_down : down_q;
  assign wrap = step && (step_down ? (cnt_q == '0) : (cnt_q >= arr_sh_q));
  assign update_event = wrap || force_upd;
  assign opm_stop = wrap && single_q && !enc_mode;

  always_ff @(posedge core_clk) begin
    if (rst || force_upd) begin
      psc_cnt_q <= '0;
    end else if (src_evt) begin
      psc_cnt_q <= psc_tick ? '0 : psc_cnt_q + 1'b1;
    end
  end

  // Shadow loads at update; direct load when preload is off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arr_sh_q <= CW'(`TOPE_RST_RELOAD);
      ccr_sh_q <= '0;
      psc_sh_q <= '0;
    end else begin
      if (update_event || !perpre_q) arr_sh_q <= arr_q;
      if (update_event || !cpre_q) ccr_sh_q <= ccr_q;
      if (update_event) psc_sh_q <= psc_q;
    end
  end

  // Counter: wraps 0..reload either way software write wins over stepping
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (wr_count) begin
      cnt_q <= pwdata[CW-1:0];
    end else if (force_upd) begin
      cnt_q <= down_q ? arr_q : '0;
    end else if (wrap) begin
      cnt_q <= step_down ? arr_sh_q : '0;
    end else if (step) begin
      cnt_q <= step_down ? cnt_q - 1'b1 : cnt_q + 1'b1;
    end
  end

  // Run flag: trigger set beats software clear and single-shot stop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (trig) begin
      run_q <= 1'b1;
    end else if (wr_ctrl) begin
      run_q <= pwdata[`TOPE_CTRL_RUN];
    end else if (opm_stop) begin
      run_q <= 1'b0;
    end
  end

  // Direction flag: hardware encoder transitions win over software writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      down_q <= 1'b0;
    end else if (enc_mode && enc_valid) begin
      down_q <= enc_down;
    end else if (wr_ctrl) begin
      down_q <= pwdata[`TOPE_CTRL_DOWN];
    end
  end

  // Output reference; fast path forces match level until compare catches up
  logic below, match, at_top, fast_hit;
  assign below = cnt_q < ccr_sh_q;
  assign match = (cnt_q == ccr_sh_q);
  assign at_top = (cnt_q == arr_sh_q); // Pulse ends as the count reaches reload
  assign fast_hit = trig && fast_q && pwm_mode(ocm_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      match_q <= 1'b0;
      fast_hold_q <= 1'b0;
    end else begin
      match_q <= match;
      if (fast_hit) fast_hold_q <= 1'b1;
      else if (!below || update_event || !pwm_mode(ocm_q)) fast_hold_q <= 1'b0;
    end
  end

  // Delay is compare ticks; width is reload minus compare in PWM mode 2, one tick more in PWM mode 1
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_q <= 1'b0;
    end else begin
      case (ocm_q)
        `TOPE_OCM_FROZEN: ref_q <= ref_q;
        `TOPE_OCM_ACTIVE: if (match) ref_q <= 1'b1;
        `TOPE_OCM_INACTIVE: if (match) ref_q <= 1'b0;
        `TOPE_OCM_TOGGLE: if (match && !match_q) ref_q <= !ref_q;
        `TOPE_OCM_FORCE_LO: ref_q <= 1'b0;
        `TOPE_OCM_FORCE_HI: ref_q <= 1'b1;
        `TOPE_OCM_PWM1: ref_q <= (fast_hit || fast_hold_q) ? 1'b0 : below;
        `TOPE_OCM_PWM2: ref_q <= (fast_hit || fast_hold_q) ? 1'b1 : (!below && !at_top);
        default: ref_q <= 1'b0;
      endcase
    end
  end

  assign output_reference = ref_q;
  assign counter_value = cnt_q;
  assign count_down_flag = down_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_opm_stop_run: assert property (opm_stop && !trig |=> !run_q)
    else $error("counter still running after single-shot update");
  a_repeat_keeps: assert property (wrap && !single_q && run_q && !wr_ctrl |=> run_q)
    else $error("counter stopped in repetitive mode");
  a_trig_starts: assert property (trig |=> run_q)
    else $error("trigger edge did not start counter");
  a_pwm2_level: assert property (ocm_q == `TOPE_OCM_PWM2 && !fast_hit && !fast_hold_q
                                 |=> ref_q == $past(!below && !at_top))
    else $error("PWM mode 2 level wrong");
  a_fast_force: assert property (fast_hit && ocm_q == `TOPE_OCM_PWM2
                                 ##1 ocm_q == `TOPE_OCM_PWM2 |-> ref_q)
    else $error("fast enable did not force output");
  a_fast_ignored: assert property (trig && fast_q && ocm_q == `TOPE_OCM_ACTIVE && !match
                                   |=> ref_q == $past(ref_q) && !fast_hold_q)
    else $error("fast enable acted outside PWM");
  a_dual_edge_hold: assert property (enc_mode && a_edge && b_edge && !wr_count && !force_upd
                                     |=> $stable(cnt_q))
    else $error("counter moved on simultaneous edges");
  a_enc_wrap_up: assert property (enc_count && !enc_down && psc_tick && cnt_q >= arr_sh_q && !wr_count
                                  && !force_upd |=> cnt_q == '0)
    else $error("encoder up-count did not wrap to zero");
  a_dir_track: assert property (enc_mode && enc_valid |=> down_q == $past(enc_down))
    else $error("direction flag not updated");
  a_enc_idle: assert property (enc_mode && !run_q && !wr_count && !force_upd |=> $stable(cnt_q))
    else $error("encoder counted while stopped");
  a_force_load: assert property (force_upd |=> arr_sh_q == $past(arr_q) && ccr_sh_q == $past(ccr_q))
    else $error("force update did not load shadows");

  c_trig_start: cover property (trig ##1 run_q);
  c_fast_pulse: cover property (fast_hit ##1 ref_q);
  c_enc_up_down: cover property (enc_count && !enc_down ##[1:20] enc_count && enc_down);
  c_single_stop: cover property (opm_stop ##1 !run_q);
endmodule

// file: design/tope_params.svh
// Register offsets, field positions, encodings and reset values of the pulse/encoder timer
`ifndef TOPE_PARAMS_SVH
`define TOPE_PARAMS_SVH

`define TOPE_OFS_CTRL 12'h000
`define TOPE_OFS_SMODE 12'h008
`define TOPE_OFS_EVGEN 12'h014
`define TOPE_OFS_CHMODE 12'h018
`define TOPE_OFS_CAPEN 12'h020
`define TOPE_OFS_COUNT 12'h024
`define TOPE_OFS_PRESC 12'h028
`define TOPE_OFS_RELOAD 12'h02C
`define TOPE_OFS_CMP1 12'h034

`define TOPE_CTRL_RUN 0
`define TOPE_CTRL_SINGLE 3
`define TOPE_CTRL_DOWN 4
`define TOPE_CTRL_PERPRE 7
`define TOPE_SMODE_SMS 2:0
`define TOPE_SMODE_TS 6:4
`define TOPE_EVGEN_UPD 0
`define TOPE_CH_SEL1 1:0
`define TOPE_CH_FAST 2
`define TOPE_CH_CPRE 3
`define TOPE_CH_OCM 6:4
`define TOPE_CH_SEL2 9:8
`define TOPE_CH_FLTA 19:16
`define TOPE_CH_FLTB 23:20
`define TOPE_CAP_POLA 1
`define TOPE_CAP_POLB 5

`define TOPE_SMS_ENC_B 3'h1
`define TOPE_SMS_ENC_A 3'h2
`define TOPE_SMS_ENC_AB 3'h3
`define TOPE_SMS_TRIG 3'h6
`define TOPE_TS_INA 3'h5
`define TOPE_TS_INB 3'h6
`define TOPE_SEL_DIRECT 2'h1

`define TOPE_OCM_FROZEN 3'h0
`define TOPE_OCM_ACTIVE 3'h1
`define TOPE_OCM_INACTIVE 3'h2
`define TOPE_OCM_TOGGLE 3'h3
`define TOPE_OCM_FORCE_LO 3'h4
`define TOPE_OCM_FORCE_HI 3'h5
`define TOPE_OCM_PWM1 3'h6
`define TOPE_OCM_PWM2 3'h7

`define TOPE_RST_WORD 32'h0000_0000
`define TOPE_RST_RELOAD 32'h0000_FFFF

`endif

// file: design/tope_pkg.sv
// Types shared by the pulse/encoder timer modules
package tope_pkg;
  typedef enum logic [0:0] {
    TOPE_AP_IDLE,
    TOPE_AP_RESP
  } tope_apb_st_t;
  typedef logic [31:0] tope_word_t;
endpackage

// file: design/tope_input_cond.sv
// Input conditioner: polarity, digital filter and edge pulses for one timer input
`timescale 1ns/1ps
module tope_input_cond
  import tope_pkg::*;
#(
  parameter int FW = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic raw_in,
  input wire logic invert,
  input wire logic [FW-1:0] filter_len,
  output logic level_q,
  output logic rise_q,
  output logic fall_q
);
  if (FW < 1 || FW > 8) begin : g_bad_fw
    $error("tope_input_cond: FW out of range");
  end

  logic pol_in;
  logic [FW-1:0] stable_q;

  // Inversion before filtering so edges are judged on the chosen sense
  assign pol_in = raw_in ^ invert;

  // Filter: a new level is taken only after filter_len+1 agreeing samples
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stable_q <= '0;
      level_q <= 1'b0;
    end else if (pol_in == level_q) begin
      stable_q <= '0;
    end else if (stable_q >= filter_len) begin
      stable_q <= '0;
      level_q <= pol_in;
    end else begin
      stable_q <= stable_q + 1'b1;
    end
  end

  // Edge pulses aligned with the level change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= (pol_in != level_q) && (stable_q >= filter_len) && pol_in;
      fall_q <= (pol_in != level_q) && (stable_q >= filter_len) && !pol_in;
    end
  end
endmodule

// file: bench/tope_enc_model.sv
// Encoder and trigger source that drives the two raw timer inputs
`timescale 1ns/1ps
module tope_enc_model (
  input wire logic core_clk,
  output logic enc_a,
  output logic enc_b
);
  // Push-pull lines, low until the first move
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // New levels just after a rising edge, then held so the filter can accept them
  task automatic drive(input logic na, input logic nb, input int hold);
    begin
      @(posedge core_clk);
      enc_a <= na;
      enc_b <= nb;
      repeat (hold) @(posedge core_clk);
    end
  endtask
endmodule

// file: bench/tope_timer_tb_top.sv
// Self-checking bench for the pulse/encoder timer
`timescale 1ns/1ps
`include "tope_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tope_timer_tb_top
  import tope_pkg::*;
;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic enc_a, enc_b, output_reference, count_down_flag;
  logic [11:0] paddr;
  tope_word_t pwdata, prdata, rd;
  logic [15:0] counter_value, ec;
  logic la, lb, pol_a, ed, run_on;
  int n_fail, compares, cyc, mode, rl, presc, pc, hi, bad, rises;
  // Quadrature states: forward run with a wrap, then back again
  logic [1:0] fw [7] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b10, 2'b00, 2'b01};
  logic [1:0] gr [4] = '{2'b01, 2'b00, 2'b10, 2'b11};

  tope_timer #(.CW(16), .PW(16)) tope_timer_i (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .encoder_input_a(enc_a), .encoder_input_b(enc_b),
    .output_reference(output_reference), .counter_value(counter_value),
    .count_down_flag(count_down_flag));
  tope_enc_model tope_enc_model_i (.core_clk(core_clk), .enc_a(enc_a), .enc_b(enc_b));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run;
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // APB transfer; request held until pready is seen high at a rising edge, answer taken there
  task automatic xfer(input logic wr, input logic [11:0] a, input tope_word_t wd);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // One counter step of the expected model, prescaled by presc+1 events
  task automatic tick(input logic up);
    begin
      pc++;
      if (pc > presc) begin
        pc = 0;
        if (up) ec = (ec == rl) ? 16'h0000 : ec + 16'h0001;
        else ec = (ec == 16'h0000) ? 16'(rl) : ec - 16'h0001;
      end
    end
  endtask
  // Move the encoder lines and compare position and direction
  task automatic move(input logic na, input logic nb);
    logic ea, up;
    begin
      ea = (na != la);
      if (ea != (nb != lb) && run_on) begin
        up = ea ? ((na ^ pol_a) ^ lb) : !(nb ^ la ^ pol_a);
        ed = !up;
        if (ea ? mode != 1 : mode != 2) tick(up);
      end
      la = na;
      lb = nb;
      tope_enc_model_i.drive(na, nb, 8);
      @(negedge core_clk);
      `CHK(counter_value, ec)
      if (run_on) `CHK(count_down_flag, ed)
    end
  endtask
  // Arm a one-pulse or repetitive run (per single) and fire the trigger on input B
  task automatic op_run(input int r, input int cp, input logic [2:0] ocm, input logic fast,
                        input logic single);
    begin
      rl = r;
      xfer(1'b1, `TOPE_OFS_CTRL, 32'h0000_0000);
      xfer(1'b1, `TOPE_OFS_CHMODE, {22'h0, 2'h1, 1'b0, ocm, 1'b1, fast, 2'h1});
      xfer(1'b1, `TOPE_OFS_RELOAD, 32'(r));
      xfer(1'b1, `TOPE_OFS_CMP1, 32'(cp));
      xfer(1'b1, `TOPE_OFS_SMODE, {25'h0, `TOPE_TS_INB, 1'b0, `TOPE_SMS_TRIG});
      xfer(1'b1, `TOPE_OFS_CTRL, {24'h0, 1'b1, 3'h0, single, 3'h0});
      xfer(1'b1, `TOPE_OFS_EVGEN, 32'h0000_0001);
      tope_enc_model_i.drive(1'b1, 1'b0, 6);
      @(negedge core_clk);
      `CHK(counter_value, 16'h0000)
      tope_enc_model_i.drive(1'b0, 1'b0, 6);
      tope_enc_model_i.drive(1'b0, 1'b1, 0);
    end
  endtask
  // Watch the output against the counter; a one-cycle lag is tolerated at each edge
  task automatic watch(input int n, input int cp);
    logic pv;
    begin
      hi = 0;
      bad = 0;
      rises = 0;
      pv = output_reference;
      repeat (n) begin
        @(negedge core_clk);
        if (output_reference === 1'b1) hi++;
        if (output_reference === 1'b1 && pv !== 1'b1) rises++;
        if (counter_value > 0 && counter_value < cp && output_reference !== 1'b0) bad++;
        if (counter_value > cp && counter_value <= rl && output_reference !== 1'b1) bad++;
        pv = output_reference;
      end
    end
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {la, lb, pol_a, ed, run_on} = 5'b0_0000;
    ec = 16'h0000;
    {mode, rl, presc, pc} = {32'd3, 32'd3, 32'd0, 32'd0};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    xfer(1'b0, `TOPE_OFS_RELOAD, 32'h0000_0000);
    `CHK(rd, `TOPE_RST_RELOAD)
    xfer(1'b0, 12'h0FC, 32'h0000_0000);
    `CHK(er, 1'b1)
    // Encoder on both inputs, short reload so it wraps both ways
    xfer(1'b1, `TOPE_OFS_CHMODE, 32'h0000_0101);
    xfer(1'b1, `TOPE_OFS_RELOAD, 32'h0000_0003);
    xfer(1'b1, `TOPE_OFS_SMODE, 32'h0000_0003);
    xfer(1'b1, `TOPE_OFS_CTRL, 32'h0000_0001);
    run_on = 1'b1;
    foreach (fw[i]) move(fw[i][1], fw[i][0]);
    move(1'b1, 1'b0);
    move(1'b1, 1'b1);
    // Single-input modes
    for (int m = 1; m <= 2; m++) begin
      mode = m;
      xfer(1'b1, `TOPE_OFS_SMODE, 32'(m));
      foreach (gr[i]) move(gr[i][1], gr[i][0]);
    end
    xfer(1'b0, `TOPE_OFS_COUNT, 32'h0000_0000);
    `CHK(rd, {16'h0000, ec})
    // Stopped counter ignores edges
    xfer(1'b1, `TOPE_OFS_CTRL, 32'h0000_0000);
    run_on = 1'b0;
    move(1'b1, 1'b0);
    move(1'b1, 1'b1);
    // Inverted and filtered input A; settings change only while stopped
    pol_a = 1'b1;
    mode = 3;
    xfer(1'b1, `TOPE_OFS_CHMODE, 32'h0003_0101);
    xfer(1'b1, `TOPE_OFS_CAPEN, 32'h0000_0002);
    xfer(1'b1, `TOPE_OFS_COUNT, 32'h0000_0000);
    xfer(1'b1, `TOPE_OFS_SMODE, 32'h0000_0003);
    xfer(1'b1, `TOPE_OFS_CTRL, 32'h0000_0001);
    ec = 16'h0000;
    run_on = 1'b1;
    foreach (gr[i]) move(gr[i][1], gr[i][0]);
    // Prescaler keeps working: two events per step
    presc = 1;
    xfer(1'b1, `TOPE_OFS_PRESC, 32'h0000_0001);
    xfer(1'b1, `TOPE_OFS_EVGEN, 32'h0000_0001);
    ec = ed ? 16'(rl) : 16'h0000;
    pc = 0;
    foreach (gr[i]) move(gr[i][1], gr[i][0]);
    // One-pulse section; encoder mode never combined with an external clock
    xfer(1'b1, `TOPE_OFS_CTRL, 32'h0000_0000);
    xfer(1'b1, `TOPE_OFS_PRESC, 32'h0000_0000);
    xfer(1'b1, `TOPE_OFS_CAPEN, 32'h0000_0000);
    tope_enc_model_i.drive(1'b0, 1'b0, 4);
    op_run(12, 4, `TOPE_OCM_PWM2, 1'b0, 1'b1);
    watch(40, 4);
    `CHK(hi, 12 - 4)
    `CHK(rises, 1)
    `CHK(bad, 0)
    `CHK(counter_value, 16'h0000)
    xfer(1'b0, `TOPE_OFS_CTRL, 32'h0000_0000);
    `CHK(rd[`TOPE_CTRL_RUN], 1'b0)
    // Repetitive mode keeps producing pulses
    op_run(12, 8, `TOPE_OCM_PWM2, 1'b0, 1'b0);
    watch(45, 8);
    `CHK(rises >= 2, 1'b1)
    `CHK(bad, 0)
    do @(negedge core_clk); while (counter_value !== 16'h0000);
    xfer(1'b1, `TOPE_OFS_CTRL, 32'h0000_0000);
    // Fast path: output set long before the compare match
    op_run(20, 15, `TOPE_OCM_PWM2, 1'b1, 1'b1);
    repeat (6) @(negedge core_clk);
    `CHK(output_reference, 1'b1)
    `CHK(counter_value < 16'd15, 1'b1)
    repeat (30) @(negedge core_clk);
    // Fast enable has no effect outside the PWM modes
    op_run(20, 15, `TOPE_OCM_ACTIVE, 1'b1, 1'b1);
    repeat (6) @(negedge core_clk);
    `CHK(output_reference, 1'b0)
    complete_run();
  end
endmodule
